// ===== core/teic_core.sv
// Transmit errored-packet insertion control with packet/byte counters.
// Assumes packet and byte strobes come from logic on the same clock;
// the manual error strobe is an asynchronous pin.
//
// Notes on behaviour
// - Writing initiate one starts new insertion
// - Finished set after programmed errored packets
// - Finished cleared on disable or restart
// - Latched bit set on finished rising
// - Interrupt only when enable bit set
// - 24-bit count of sent packets
// - Packet count read as three bytes
// - 32-bit count of sent bytes
// - Byte count read as four bytes
// - Stop after count; all ones continuous
// - One in x times ten to y corrupted
// - Manual strobe edge inserts one error
// - Update edge snapshots counts, restarts counters
`timescale 1ns/100ps
module teic_core
  import teic_pkg::*;
(
  input  wire logic           clk_in,
  input  wire logic           srst_in,
  input  wire teic_axil_req_t axil_req_in,
  output teic_axil_rsp_t      axil_rsp_out,
  input  wire logic           pkt_start_in,
  input  wire logic           pkt_byte_in,
  input  wire logic           manual_error_strobe_in,
  output logic                pkt_corrupt_out,
  output logic                irq_out
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0]  errored_packet_count_ctrl_r;
  logic [7:0]  errored_packet_rate_ctrl_r;
  logic        insert_finished_irq_en_r;
  logic        counter_update_request_r;
  logic        insert_finished_r;
  logic        insert_finished_latched_r;
  logic        active_r;
  logic [23:0] rate_cnt_r;
  logic [7:0]  err_sent_r;
  logic        manual_pend_r;
  logic [2:0]  strobe_sync_r;
  logic        strobe_level_r;
  logic [23:0] live_pkt_r;
  logic [31:0] live_byte_r;
  logic [23:0] tx_packet_count_r;
  logic [31:0] tx_byte_count_r;
  // Bus slave state
  logic        aw_held_r;
  logic        w_held_r;
  logic [9:0]  aw_idx_r;
  logic [7:0]  w_byte_r;
  logic        w_lane_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  // ---------------------------------------------------------------
  // Rate period x * 10^y
  // ---------------------------------------------------------------
  function automatic logic [23:0] rate_period(input logic [6:0] rate);
    logic [2:0]  y;
    logic [23:0] pw;
    y = (rate[6:4] > RATE_EXP_MAX) ? RATE_EXP_MAX : rate[6:4];
    case (y)
      3'h0:    pw = 24'h000001;
      3'h1:    pw = 24'h00000a;
      3'h2:    pw = 24'h000064;
      3'h3:    pw = 24'h0003e8;
      3'h4:    pw = 24'h002710;
      3'h5:    pw = 24'h0186a0;
      default: pw = 24'h0f4240;
    endcase
    return 24'(24'(rate[3:0]) * pw);
  endfunction : rate_period

  // ---------------------------------------------------------------
  // Register write path
  // ---------------------------------------------------------------
  logic wr_fire;
  logic wr_ok;
  logic wr_initiate;
  logic wr_lat_clear;
  logic rate_disabled;
  always_comb begin
    wr_fire      = aw_held_r && w_held_r && !bvalid_r;
    wr_ok        = wr_fire && w_lane_r;
    wr_initiate  = wr_ok && (aw_idx_r == IDX_CTRL_LOW)
                   && w_byte_r[POS_INITIATE];
    wr_lat_clear = wr_ok && (aw_idx_r == IDX_STATUS_LAT)
                   && w_byte_r[POS_FINISHED];
    rate_disabled = (errored_packet_rate_ctrl_r[3:0] == 4'h0);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      errored_packet_count_ctrl_r <= RST_BYTE;
      errored_packet_rate_ctrl_r  <= RST_BYTE;
      insert_finished_irq_en_r    <= 1'b0;
      counter_update_request_r    <= 1'b0;
    end else if (wr_ok) begin
      if (aw_idx_r == IDX_COUNT_CTRL) begin
        errored_packet_count_ctrl_r <= w_byte_r;
      end else if (aw_idx_r == IDX_RATE_CTRL) begin
        errored_packet_rate_ctrl_r <= w_byte_r;
      end else if (aw_idx_r == IDX_IRQ_EN) begin
        insert_finished_irq_en_r <= w_byte_r[POS_IRQ_EN];
      end else if (aw_idx_r == IDX_CNT_UPDATE) begin
        counter_update_request_r <= w_byte_r[POS_UPDATE];
      end
    end
  end

  // ---------------------------------------------------------------
  // Manual strobe synchroniser and edge
  // ---------------------------------------------------------------
  logic strobe_rise;
  assign strobe_rise = strobe_sync_r[1] && strobe_sync_r[2]
                       && !strobe_level_r;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      strobe_sync_r  <= 3'h0;
      strobe_level_r <= 1'b0;
    end else begin
      strobe_sync_r <= {strobe_sync_r[1:0], manual_error_strobe_in};
      if (strobe_sync_r[1] == strobe_sync_r[2]) begin
        strobe_level_r <= strobe_sync_r[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // Insertion engine
  // ---------------------------------------------------------------
  logic        auto_hit;
  logic        done_hit;
  logic [23:0] rate_next;
  always_comb begin
    rate_next = 24'(rate_cnt_r + 24'h000001);
    auto_hit  = pkt_start_in && active_r && !rate_disabled
                && (rate_next >= rate_period(
                    errored_packet_rate_ctrl_r[6:0]));
    done_hit  = active_r
                && (errored_packet_count_ctrl_r != COUNT_CONTINUOUS)
                && (err_sent_r == errored_packet_count_ctrl_r);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      active_r   <= 1'b0;
      rate_cnt_r <= 24'h000000;
      err_sent_r <= 8'h00;
    end else if (wr_initiate) begin
      active_r   <= 1'b1;
      rate_cnt_r <= 24'h000000;
      err_sent_r <= 8'h00;
    end else if (done_hit || rate_disabled) begin
      active_r <= 1'b0;
    end else if (pkt_start_in && active_r) begin
      rate_cnt_r <= auto_hit ? 24'h000000 : rate_next;
      if (auto_hit) begin
        err_sent_r <= 8'(err_sent_r + 8'h01);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      manual_pend_r <= 1'b0;
    end else if (strobe_rise
                 && errored_packet_rate_ctrl_r[POS_MANUAL_SEL]) begin
      manual_pend_r <= 1'b1;
    end else if (pkt_start_in) begin
      manual_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pkt_corrupt_out <= 1'b0;
    end else begin
      pkt_corrupt_out <= auto_hit
                         || (pkt_start_in && manual_pend_r);
    end
  end

  // ---------------------------------------------------------------
  // Finished status, latch and interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      insert_finished_r <= 1'b0;
    end else if (done_hit && !wr_initiate) begin
      insert_finished_r <= 1'b1;
    end else if (wr_initiate || rate_disabled) begin
      insert_finished_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      insert_finished_latched_r <= 1'b0;
    end else if (done_hit && !wr_initiate && !insert_finished_r) begin
      insert_finished_latched_r <= 1'b1;
    end else if (wr_lat_clear) begin
      insert_finished_latched_r <= 1'b0;
    end
  end

  assign irq_out = insert_finished_latched_r
                   && insert_finished_irq_en_r;

  // ---------------------------------------------------------------
  // Performance counters
  // ---------------------------------------------------------------
  logic update_edge;
  logic update_prev_r;
  assign update_edge = counter_update_request_r && !update_prev_r;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      update_prev_r     <= 1'b0;
      live_pkt_r        <= 24'h000000;
      live_byte_r       <= 32'h00000000;
      tx_packet_count_r <= 24'h000000;
      tx_byte_count_r   <= 32'h00000000;
    end else begin
      update_prev_r <= counter_update_request_r;
      if (update_edge) begin
        tx_packet_count_r <= live_pkt_r;
        tx_byte_count_r   <= live_byte_r;
        live_pkt_r        <= {23'h000000, pkt_start_in};
        live_byte_r       <= {31'h00000000, pkt_byte_in};
      end else begin
        live_pkt_r  <= 24'(live_pkt_r + {23'h000000, pkt_start_in});
        live_byte_r <= 32'(live_byte_r + {31'h00000000, pkt_byte_in});
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_idx_r  <= 10'h000;
      w_byte_r  <= 8'h00;
      w_lane_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (axil_req_in.awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        aw_idx_r  <= axil_req_in.awaddr[11:2];
      end
      if (axil_req_in.wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        w_byte_r <= axil_req_in.wdata[7:0];
        w_lane_r <= axil_req_in.wstrb[0];
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        if ((aw_idx_r == IDX_CTRL_LOW) || (aw_idx_r == IDX_COUNT_CTRL)
            || (aw_idx_r == IDX_RATE_CTRL) || (aw_idx_r == IDX_IRQ_EN)
            || (aw_idx_r == IDX_STATUS_LAT)
            || (aw_idx_r == IDX_CNT_UPDATE)) begin
          bresp_r <= RESP_OKAY;
        end else begin
          bresp_r <= RESP_SLVERR;
        end
      end else if (bvalid_r && axil_req_in.bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  logic [9:0] ar_idx;
  logic [7:0] rd_byte;
  logic       rd_hit;
  always_comb begin
    ar_idx  = axil_req_in.araddr[11:2];
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (ar_idx == IDX_CTRL_LOW) begin
      rd_byte = 8'h00;                    // Initiate bit is write-only
    end else if (ar_idx == IDX_COUNT_CTRL) begin
      rd_byte = errored_packet_count_ctrl_r;
    end else if (ar_idx == IDX_RATE_CTRL) begin
      rd_byte = errored_packet_rate_ctrl_r;
    end else if (ar_idx == IDX_STATUS) begin
      rd_byte = {7'h00, insert_finished_r};
    end else if (ar_idx == IDX_STATUS_LAT) begin
      rd_byte = {7'h00, insert_finished_latched_r};
    end else if (ar_idx == IDX_IRQ_EN) begin
      rd_byte = {7'h00, insert_finished_irq_en_r};
    end else if (ar_idx == IDX_PKT_B0) begin
      rd_byte = tx_packet_count_r[7:0];
    end else if (ar_idx == IDX_PKT_B1) begin
      rd_byte = tx_packet_count_r[15:8];
    end else if (ar_idx == IDX_PKT_B2) begin
      rd_byte = tx_packet_count_r[23:16];
    end else if (ar_idx == IDX_BYTE_B0) begin
      rd_byte = tx_byte_count_r[7:0];
    end else if (ar_idx == IDX_BYTE_B1) begin
      rd_byte = tx_byte_count_r[15:8];
    end else if (ar_idx == IDX_BYTE_B2) begin
      rd_byte = tx_byte_count_r[23:16];
    end else if (ar_idx == IDX_BYTE_B3) begin
      rd_byte = tx_byte_count_r[31:24];
    end else if (ar_idx == IDX_CNT_UPDATE) begin
      rd_byte = {7'h00, counter_update_request_r};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= RESP_OKAY;
    end else if (axil_req_in.arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h000000, rd_byte};
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && axil_req_in.rready) begin
      rvalid_r <= 1'b0;
    end
  end

  always_comb begin
    axil_rsp_out.awready = !aw_held_r;
    axil_rsp_out.wready  = !w_held_r;
    axil_rsp_out.bvalid  = bvalid_r;
    axil_rsp_out.bresp   = bresp_r;
    axil_rsp_out.arready = !rvalid_r;
    axil_rsp_out.rvalid  = rvalid_r;
    axil_rsp_out.rdata   = rdata_r;
    axil_rsp_out.rresp   = rresp_r;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_done;
    done_hit && !wr_initiate;
  endsequence
  sequence s_restart;
    wr_initiate;
  endsequence

  a_finish_set: assert property (
    s_done |=> insert_finished_r && !active_r)
    else $error("finished not set after last errored packet");
  a_finish_clear: assert property (
    s_restart ##0 !done_hit |=> !insert_finished_r && active_r)
    else $error("finished not cleared on restart");
  a_finish_off: assert property (
    rate_disabled && !done_hit |=> !insert_finished_r)
    else $error("finished not cleared while disabled");
  a_latch_rise: assert property (
    $rose(insert_finished_r) |-> insert_finished_latched_r)
    else $error("latched bit missed finished rise");
  a_irq_gate: assert property (
    !insert_finished_irq_en_r |-> !irq_out)
    else $error("interrupt raised while disabled");
  a_irq_level: assert property (
    insert_finished_latched_r && insert_finished_irq_en_r |-> irq_out)
    else $error("interrupt missing while latched and enabled");
  a_pkt_count: assert property (
    pkt_start_in && !update_edge |=> live_pkt_r == $past(live_pkt_r) + 1)
    else $error("packet count did not advance");
  a_byte_count: assert property (
    !pkt_byte_in && !update_edge |=> $stable(live_byte_r))
    else $error("byte count moved without a byte");
  a_snapshot: assert property (
    update_edge |=> tx_byte_count_r == $past(live_byte_r))
    else $error("snapshot did not take live byte count");
  a_every_pkt: assert property (
    pkt_start_in && active_r && !done_hit && !rate_disabled
    && errored_packet_rate_ctrl_r[6:0] == 7'h01 |=> pkt_corrupt_out)
    else $error("rate one did not corrupt packet");
  a_continuous: assert property (
    active_r && errored_packet_count_ctrl_r == COUNT_CONTINUOUS
    && !rate_disabled |=> active_r)
    else $error("continuous insertion stopped");
endmodule : teic_core

// ===== core/teic_pkg.sv
// Package of the transmit error-insertion and counter block.
// Assumes a single 125 MHz clock and an AXI4-Lite register bus.
package teic_pkg;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_CTRL_LOW      = 10'h0c4;
  localparam logic [9:0] IDX_COUNT_CTRL    = 10'h0c6;
  localparam logic [9:0] IDX_RATE_CTRL     = 10'h0c7;
  localparam logic [9:0] IDX_STATUS        = 10'h0c8;
  localparam logic [9:0] IDX_STATUS_LAT    = 10'h0c9;
  localparam logic [9:0] IDX_IRQ_EN        = 10'h0ca;
  localparam logic [9:0] IDX_PKT_B0        = 10'h0cc;
  localparam logic [9:0] IDX_PKT_B1        = 10'h0cd;
  localparam logic [9:0] IDX_PKT_B2        = 10'h0ce;
  localparam logic [9:0] IDX_BYTE_B0       = 10'h0d0;
  localparam logic [9:0] IDX_BYTE_B1       = 10'h0d1;
  localparam logic [9:0] IDX_BYTE_B2       = 10'h0d2;
  localparam logic [9:0] IDX_BYTE_B3       = 10'h0d3;
  localparam logic [9:0] IDX_CNT_UPDATE    = 10'h0d6;
  // ---------------------------------------------------------------
  // Field positions and values
  // ---------------------------------------------------------------
  localparam int         POS_INITIATE      = 0;
  localparam int         POS_FINISHED      = 0;
  localparam int         POS_IRQ_EN        = 0;
  localparam int         POS_UPDATE        = 0;
  localparam int         POS_MANUAL_SEL    = 7;
  localparam logic [7:0] COUNT_CONTINUOUS  = 8'hff;
  localparam logic [2:0] RATE_EXP_MAX      = 3'h6;
  localparam logic [7:0] RST_BYTE          = 8'h00;
  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_SLVERR       = 2'h2;
  // ---------------------------------------------------------------
  // Bus carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } teic_axil_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } teic_axil_rsp_t;
endpackage : teic_pkg

// ===== sim/teic_pkt_src.sv
// Packet source model standing at the block's transmit side.
// Assumes the same clock and reset as the block; sends num_in packets
// of LEN bytes each, one idle cycle between packets.
`timescale 1ns/100ps
module teic_pkt_src #(
  parameter int LEN = 8
) (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       go_in,
  input  wire logic [7:0] num_in,
  output logic            pkt_start_out,
  output logic            pkt_byte_out,
  output logic            busy_out
);
  logic [7:0] left_r;
  logic [4:0] ph_r;

  // ---------------------------------------------------------------
  // Packet sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      left_r <= 8'h00;
      ph_r   <= 5'h00;
    end else if (go_in) begin
      left_r <= num_in;
      ph_r   <= 5'h00;
    end else if (left_r != 8'h00) begin
      if (ph_r == 5'(LEN)) begin
        ph_r   <= 5'h00;
        left_r <= left_r - 8'h01;
      end else begin
        ph_r <= ph_r + 5'h01;
      end
    end
  end

  assign busy_out      = (left_r != 8'h00);
  assign pkt_start_out = busy_out && (ph_r == 5'h00);
  assign pkt_byte_out  = busy_out && (ph_r < 5'(LEN));
endmodule : teic_pkt_src

// ===== sim/tb.sv
// Self-checking bench of the error-insertion and counter block.
// Assumes teic_pkg, teic_core and teic_pkt_src are compiled first.
`timescale 1ns/100ps
module tb;
  import teic_pkg::*;
  localparam int LEN = 8;
  typedef struct {
    logic [7:0] cnt;
    logic [7:0] rate;
    logic [7:0] npk;
    int         errs;
    logic       fin;
    logic       ien;
  } teic_row_t;

  logic           clk_in = 1'b0;
  logic           srst_in = 1'b1;
  teic_axil_req_t req = '0;
  teic_axil_rsp_t rsp;
  logic           go = 1'b0;
  logic           strobe = 1'b0;
  logic [7:0]     num = 8'h00;
  logic           pkt_start, pkt_byte, corrupt, irq, busy;
  int             n_errors = 0, check_count = 0, n_corrupt = 0, tot = 0;
  logic [31:0]    d;
  logic [1:0]     resp;
  logic [23:0]    epk;
  logic [31:0]    eby;
  teic_row_t      rows [5] = '{'{8'h03, 8'h01, 8'd5, 3, 1'b1, 1'b1},
                               '{8'hff, 8'h02, 8'd6, 3, 1'b0, 1'b1},
                               '{8'h02, 8'h11, 8'd20, 2, 1'b1, 1'b0},
                               '{8'h01, 8'h0f, 8'd15, 1, 1'b1, 1'b1},
                               '{8'h05, 8'h00, 8'd4, 0, 1'b0, 1'b1}};
  logic [9:0]     ridx [11] = '{IDX_STATUS, IDX_STATUS_LAT, IDX_IRQ_EN,
                                IDX_PKT_B0, IDX_PKT_B1, IDX_PKT_B2,
                                IDX_BYTE_B0, IDX_BYTE_B1, IDX_BYTE_B2,
                                IDX_BYTE_B3, IDX_CTRL_LOW};

  always #4 clk_in = ~clk_in;

  teic_core u_teic_core (.clk_in(clk_in), .srst_in(srst_in),
    .axil_req_in(req), .axil_rsp_out(rsp), .pkt_start_in(pkt_start),
    .pkt_byte_in(pkt_byte), .manual_error_strobe_in(strobe),
    .pkt_corrupt_out(corrupt), .irq_out(irq));
  teic_pkt_src #(.LEN(LEN)) u_teic_pkt_src (.clk_in(clk_in),
    .srst_in(srst_in), .go_in(go), .num_in(num),
    .pkt_start_out(pkt_start), .pkt_byte_out(pkt_byte),
    .busy_out(busy));

  always @(posedge clk_in) begin
    if (corrupt === 1'b1) n_corrupt <= n_corrupt + 1;
  end

  // ---------------------------------------------------------------
  // Bus and stimulus tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [9:0] idx, input logic [7:0] v);
    @(posedge clk_in);
    req.awvalid <= 1'b1;
    req.awaddr  <= {idx, 2'b00};
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h000000, v};
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    do begin
      @(posedge clk_in);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] idx);
    @(posedge clk_in);
    req.arvalid <= 1'b1;
    req.araddr  <= {idx, 2'b00};
    req.rready  <= 1'b1;
    do begin
      @(posedge clk_in);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd

  task automatic send(input logic [7:0] n);
    @(posedge clk_in);
    go  <= 1'b1;
    num <= n;
    @(posedge clk_in);
    go <= 1'b0;
    do @(posedge clk_in); while (busy === 1'b1);
  endtask : send

  // Held long enough to pass the pin synchroniser
  task automatic pulse_strobe();
    @(posedge clk_in);
    strobe <= 1'b1;
    repeat (6) @(posedge clk_in);
    strobe <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask : pulse_strobe

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin : watchdog
    repeat (20000) @(posedge clk_in);
    n_errors++;
    conclude();
  end

  initial begin : main
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    foreach (rows[i]) begin
      wr(IDX_IRQ_EN, {7'h00, rows[i].ien});
      wr(IDX_COUNT_CTRL, rows[i].cnt);
      wr(IDX_RATE_CTRL, rows[i].rate);
      wr(IDX_CTRL_LOW, 8'h01);
      n_corrupt = 0;
      send(rows[i].npk);
      tot += rows[i].npk;
      chk(n_corrupt, rows[i].errs);
      rd(IDX_STATUS);
      chk(d, {31'h0, rows[i].fin});
      rd(IDX_STATUS_LAT);
      chk(d, {31'h0, rows[i].fin});
      chk(irq, rows[i].fin & rows[i].ien);
      wr(IDX_COUNT_CTRL, 8'h00);
      wr(IDX_RATE_CTRL, 8'h00);
      wr(IDX_CTRL_LOW, 8'h00);
      rd(IDX_STATUS);
      chk(d, 32'h0);
      wr(IDX_STATUS_LAT, 8'h01);
      chk(irq, 1'b0);
      $display("Row %0d done", i);
    end
    epk = 24'(tot);
    eby = 32'(tot * LEN);
    wr(IDX_CNT_UPDATE, 8'h01);
    for (int i = 0; i < 3; i++) begin
      rd(IDX_PKT_B0 + 10'(i));
      chk(d, {24'h0, epk[8*i +: 8]});
    end
    for (int i = 0; i < 4; i++) begin
      rd(IDX_BYTE_B0 + 10'(i));
      chk(d, {24'h0, eby[8*i +: 8]});
    end
    wr(IDX_CNT_UPDATE, 8'h00);
    send(8'd2);
    wr(IDX_CNT_UPDATE, 8'h01);
    rd(IDX_PKT_B0);
    chk(d, 32'h2);
    rd(IDX_BYTE_B0);
    chk(d, 32'(2 * LEN));
    $display("Counter test done");
    wr(IDX_COUNT_CTRL, 8'h01);
    wr(IDX_RATE_CTRL, 8'h01);
    wr(IDX_CTRL_LOW, 8'h01);
    send(8'd1);
    rd(IDX_STATUS);
    chk(d, 32'h1);
    wr(IDX_CTRL_LOW, 8'h01);
    rd(IDX_STATUS);
    chk(d, 32'h0);
    wr(IDX_COUNT_CTRL, 8'h00);
    wr(IDX_RATE_CTRL, 8'h80);
    pulse_strobe();
    n_corrupt = 0;
    send(8'd2);
    chk(n_corrupt, 32'h1);
    wr(IDX_RATE_CTRL, 8'h00);
    pulse_strobe();
    send(8'd2);
    chk(n_corrupt, 32'h1);
    $display("Manual test done");
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    chk(irq, 1'b0);
    foreach (ridx[i]) begin
      rd(ridx[i]);
      chk(d, 32'h0);
      chk(resp, RESP_OKAY);
    end
    rd(10'h0c5);
    chk(resp, RESP_SLVERR);
    wr(IDX_PKT_B0, 8'h5a);
    chk(resp, RESP_SLVERR);
    rd(IDX_PKT_B0);
    chk(d, 32'h0);
    wr(IDX_IRQ_EN, 8'h01);
    chk(resp, RESP_OKAY);
    rd(IDX_IRQ_EN);
    chk(d, 32'h1);
    $display("Reset test done");
    conclude();
  end
endmodule : tb
